// [include/ang_pkg.sv]
// Package for the auto-negotiation next-page and gigabit control registers.
// Assumes a station manager on a serial management link (clock and data).
package ang_pkg;

    // Register offsets on the management link
    localparam logic [4:0] ANG_OFS_EXPANSION = 5'h06;
    localparam logic [4:0] ANG_OFS_NP_TX     = 5'h07;
    localparam logic [4:0] ANG_OFS_LP_NP     = 5'h08;
    localparam logic [4:0] ANG_OFS_GIG_CTRL  = 5'h09;

    // Expansion status bit positions
    localparam int ANG_EXP_PD_FAULT   = 4;
    localparam int ANG_EXP_LP_NP_ABLE = 3;
    localparam int ANG_EXP_NP_ABLE    = 2;
    localparam int ANG_EXP_PAGE_RX    = 1;
    localparam int ANG_EXP_LP_AN_ABLE = 0;

    // Next-page word bit positions
    localparam int ANG_NP_MORE   = 15;
    localparam int ANG_NP_ACK    = 14;
    localparam int ANG_NP_MSG    = 13;
    localparam int ANG_NP_ACK2   = 12;
    localparam int ANG_NP_TOGGLE = 11;
    localparam int ANG_NP_CODE_W = 11;

    // Gigabit control bit positions
    localparam int ANG_GC_TM_LSB    = 13;
    localparam int ANG_GC_MS_MANUAL = 12;
    localparam int ANG_GC_MS_VALUE  = 11;
    localparam int ANG_GC_PORT_TYPE = 10;
    localparam int ANG_GC_ADV_1000F = 9;

    // Values after reset
    localparam logic       ANG_RST_NP_ABLE = 1'b1;
    localparam logic       ANG_RST_NP_MSG  = 1'b1;
    localparam logic [10:0] ANG_RST_NP_CODE = 11'h3FF;
    localparam logic [15:0] ANG_RST_LP_NP   = 16'h0000;
    localparam logic [15:0] ANG_RST_GIG     = 16'h0000;

    // Writable masks
    localparam logic [15:0] ANG_NP_TX_WMASK = 16'hB7FF;
    localparam logic [15:0] ANG_GIG_WMASK   = 16'hFE00;

    // Management frame
    localparam int          ANG_MDIO_PRE_LEN = 32;
    localparam logic [1:0]  ANG_OP_WRITE     = 2'b01;
    localparam logic [1:0]  ANG_OP_READ      = 2'b10;
    localparam logic [3:0]  ANG_HDR_LAST     = 4'hB;
    localparam logic [3:0]  ANG_DATA_LAST    = 4'hF;

    typedef enum logic [2:0] {
        MS_PRE, MS_START, MS_HDR, MS_TA, MS_DATA
    } ang_mdio_st_e;

    typedef enum logic [2:0] {
        TM_NORMAL, TM_WAVEFORM, TM_MASTER_JIT, TM_SLAVE_JIT, TM_DISTORT
    } ang_tmode_e;

    // Conditions from the negotiation datapath
    typedef struct packed {
        logic pd_fault;
        logic lp_np_able;
        logic np_able;
        logic lp_an_able;
        logic tx_toggle;
    } ang_an_stat_s;

    // Decoded gigabit control for the line side
    typedef struct packed {
        ang_tmode_e test_mode;
        logic       ms_manual;
        logic       ms_force_master;
        logic       ms_force_slave;
        logic       port_multi;
        logic       adv_1000_full;
    } ang_gig_ctrl_s;

endpackage

// [src/ang_regs.sv]
// Management registers: expansion status, next-page transmit and receive,
// upper gigabit control, behind a serial management slave.
// Assumes mdc and mdio come from another clock domain; status from clk_sys.
`timescale 1ns/10ps
module ang_regs
    import ang_pkg::*;
#(
    parameter logic [4:0] PHY_ADDR = 5'h00,
    parameter int         PRE_LEN  = ANG_MDIO_PRE_LEN
) (
    // Clock and reset
    input  wire logic          clk_sys,
    input  wire logic          rst,
    // Management link
    input  wire logic          mdc,
    input  wire logic          mdio_in,
    output logic               mdio_out,
    output logic               mdio_oe,
    // Negotiation datapath
    input  wire ang_an_stat_s  an_stat,
    input  wire logic          lp_page_vld,
    input  wire logic [15:0]   lp_page,
    // Controls out
    output logic [15:0]        np_tx_word,
    output ang_gig_ctrl_s      gig_ctrl
);

    generate
        if (PRE_LEN < 1 || PRE_LEN > 63) begin : g_bad_pre
            $error("PRE_LEN must be 1 to 63");
        end
    endgenerate

    // Two-stage synchronisers; first stage feeds only the second
    logic       mdc_s1_reg;
    logic       mdc_s2_reg;
    logic       mdc_d_reg;
    logic       mdi_s1_reg;
    logic       mdi_s2_reg;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mdc_s1_reg <= 1'b0;
            mdc_s2_reg <= 1'b0;
            mdc_d_reg  <= 1'b0;
            mdi_s1_reg <= 1'b1;
            mdi_s2_reg <= 1'b1;
        end else begin
            mdc_s1_reg <= mdc;
            mdc_s2_reg <= mdc_s1_reg;
            mdc_d_reg  <= mdc_s2_reg;
            mdi_s1_reg <= mdio_in;
            mdi_s2_reg <= mdi_s1_reg;
        end
    end

    wire logic mdc_rise = mdc_s2_reg & ~mdc_d_reg;
    wire logic bit_in   = mdi_s2_reg;

    // Frame state
    ang_mdio_st_e st_reg;
    logic [5:0]   pre_cnt_reg;
    logic [3:0]   cnt_reg;
    logic [11:0]  hdr_reg;
    logic [15:0]  sh_reg;
    logic         rd_reg;
    logic         wr_reg;

    // Decided one bit before the header is complete, so fields sit low
    wire logic [1:0] hdr_op   = hdr_reg[10:9];
    wire logic [4:0] hdr_phy  = hdr_reg[8:4];
    wire logic [4:0] cur_addr = hdr_reg[4:0];
    wire logic addr_hit = hdr_phy == PHY_ADDR;
    wire logic ta_load  = st_reg == MS_TA && mdc_rise && cnt_reg[0];
    wire logic data_end = st_reg == MS_DATA && mdc_rise
                        && cnt_reg == ANG_DATA_LAST;
    wire logic wr_commit = data_end && wr_reg;
    wire logic [15:0] wr_data = {sh_reg[14:0], bit_in};
    wire logic rd_exp   = ta_load && rd_reg
                        && cur_addr == ANG_OFS_EXPANSION;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_reg      <= MS_PRE;
            pre_cnt_reg <= 6'h00;
            cnt_reg     <= 4'h0;
            hdr_reg     <= 12'h000;
            rd_reg      <= 1'b0;
            wr_reg      <= 1'b0;
        end else if (mdc_rise) begin
            case (st_reg)
                MS_PRE: begin
                    if (bit_in) begin
                        if (pre_cnt_reg != 6'h3F) begin
                            pre_cnt_reg <= pre_cnt_reg + 6'h01;
                        end
                    end else if (pre_cnt_reg >= 6'(PRE_LEN)) begin
                        st_reg <= MS_START;
                    end else begin
                        pre_cnt_reg <= 6'h00;
                    end
                end
                MS_START: begin
                    pre_cnt_reg <= 6'h00;
                    cnt_reg     <= 4'h0;
                    st_reg      <= bit_in ? MS_HDR : MS_PRE;
                end
                MS_HDR: begin
                    hdr_reg <= {hdr_reg[10:0], bit_in};
                    cnt_reg <= cnt_reg + 4'h1;
                    if (cnt_reg == ANG_HDR_LAST) begin
                        cnt_reg <= 4'h0;
                        st_reg  <= MS_TA;
                        rd_reg  <= hdr_op == ANG_OP_READ && addr_hit;
                        wr_reg  <= hdr_op == ANG_OP_WRITE && addr_hit;
                    end
                end
                MS_TA: begin
                    cnt_reg <= cnt_reg + 4'h1;
                    if (cnt_reg[0]) begin
                        cnt_reg <= 4'h0;
                        st_reg  <= MS_DATA;
                    end
                end
                MS_DATA: begin
                    cnt_reg <= cnt_reg + 4'h1;
                    if (cnt_reg == ANG_DATA_LAST) begin
                        st_reg <= MS_PRE;
                        rd_reg <= 1'b0;
                        wr_reg <= 1'b0;
                    end
                end
                default: begin
                    st_reg <= MS_PRE;
                end
            endcase
        end
    end

    // Register state
    logic         pdf_reg;
    logic         lpnp_reg;
    logic         npc_reg;
    logic         prx_reg;
    logic         lpan_reg;
    logic         tog_reg;
    logic [15:0]  np_tx_reg;
    logic [15:0]  lp_np_reg;
    logic [15:0]  gig_reg;

    // Set wins over the read clear
    function automatic logic sticky(input logic cur, input logic set,
                                    input logic clr);
        sticky = set | (cur & ~clr);
    endfunction

    wire logic [15:0] exp_word = {11'h000, pdf_reg, lpnp_reg, npc_reg,
                                  prx_reg, lpan_reg};
    wire logic [15:0] np_word  = {np_tx_reg[15:12], tog_reg,
                                  np_tx_reg[10:0]};

    function automatic logic [15:0] rd_mux(input logic [4:0] a,
        input logic [15:0] e, input logic [15:0] t,
        input logic [15:0] p, input logic [15:0] g);
        case (a)
            ANG_OFS_EXPANSION: rd_mux = e;
            ANG_OFS_NP_TX:     rd_mux = t;
            ANG_OFS_LP_NP:     rd_mux = p;
            ANG_OFS_GIG_CTRL:  rd_mux = g;
            default:           rd_mux = 16'h0000;
        endcase
    endfunction

    wire logic [15:0] rd_word = rd_mux(cur_addr, exp_word, np_word,
                                       lp_np_reg, gig_reg);
    wire logic wr_np  = wr_commit && cur_addr == ANG_OFS_NP_TX;
    wire logic wr_gig = wr_commit && cur_addr == ANG_OFS_GIG_CTRL;

    wire logic pdf_next = sticky(pdf_reg, an_stat.pd_fault, rd_exp);
    wire logic npc_next = sticky(npc_reg, an_stat.np_able, rd_exp);
    wire logic prx_next = sticky(prx_reg, lp_page_vld, rd_exp);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pdf_reg  <= 1'b0;
            npc_reg  <= ANG_RST_NP_ABLE;
            prx_reg  <= 1'b0;
            lpnp_reg <= 1'b0;
            lpan_reg <= 1'b0;
            tog_reg  <= 1'b0;
        end else begin
            pdf_reg  <= pdf_next;
            npc_reg  <= npc_next;
            prx_reg  <= prx_next;
            lpnp_reg <= an_stat.lp_np_able;
            lpan_reg <= an_stat.lp_an_able;
            tog_reg  <= ~an_stat.tx_toggle;
        end
    end

    // Write side; read-only bits keep their masks out of reach
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            np_tx_reg <= {1'b0, 1'b0, ANG_RST_NP_MSG, 1'b0, 1'b0,
                          ANG_RST_NP_CODE};
            lp_np_reg <= ANG_RST_LP_NP;
            gig_reg   <= ANG_RST_GIG;
        end else begin
            if (wr_np) begin
                np_tx_reg <= wr_data & ANG_NP_TX_WMASK;
            end
            if (lp_page_vld) begin
                lp_np_reg <= lp_page;
            end
            if (wr_gig) begin
                gig_reg <= wr_data & ANG_GIG_WMASK;
            end
        end
    end

    // Decoded controls; reserved test codes fall back to normal
    function automatic ang_tmode_e tm_dec(input logic [2:0] c);
        case (c)
            3'h1:    tm_dec = TM_WAVEFORM;
            3'h2:    tm_dec = TM_MASTER_JIT;
            3'h3:    tm_dec = TM_SLAVE_JIT;
            3'h4:    tm_dec = TM_DISTORT;
            default: tm_dec = TM_NORMAL;
        endcase
    endfunction

    wire logic gc_man = gig_reg[ANG_GC_MS_MANUAL];
    wire logic gc_val = gig_reg[ANG_GC_MS_VALUE];
    ang_gig_ctrl_s gig_next;
    assign gig_next.test_mode = tm_dec(gig_reg[15:13]);
    assign gig_next.ms_manual = gc_man;
    assign gig_next.ms_force_master = gc_man & gc_val;
    assign gig_next.ms_force_slave  = gc_man & ~gc_val;
    assign gig_next.port_multi = gig_reg[ANG_GC_PORT_TYPE];
    assign gig_next.adv_1000_full = gig_reg[ANG_GC_ADV_1000F];

    // Output driving: change just after the sampled rising edge
    logic mdo_next;
    logic mdoe_next;
    always_comb begin
        mdo_next  = mdio_out;
        mdoe_next = mdio_oe;
        if (mdc_rise && rd_reg) begin
            if (st_reg == MS_TA && !cnt_reg[0]) begin
                mdo_next  = 1'b0;
                mdoe_next = 1'b1;
            end else if (ta_load) begin
                mdo_next = rd_word[15];
            end else if (st_reg == MS_DATA) begin
                mdo_next  = sh_reg[14];
                mdoe_next = !data_end;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sh_reg     <= 16'h0000;
            mdio_out   <= 1'b0;
            mdio_oe    <= 1'b0;
            np_tx_word <= 16'h0000;
            gig_ctrl   <= '0;
        end else begin
            if (ta_load) begin
                sh_reg <= rd_word;
            end else if (mdc_rise && st_reg == MS_DATA) begin
                sh_reg <= wr_data;
            end
            mdio_out   <= mdo_next;
            mdio_oe    <= mdoe_next;
            np_tx_word <= np_word;
            gig_ctrl   <= gig_next;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_exp_read_quiet;
        rd_exp && !an_stat.pd_fault && !an_stat.np_able && !lp_page_vld;
    endsequence

    sequence s_np_write;
        wr_np;
    endsequence

    a_pd_fault_held:
    assert property (an_stat.pd_fault ##1 !rd_exp[*2] |-> pdf_reg)
        else $error("fault flag lost before read");
    a_lp_np_mirror:
    assert property (##1 lpnp_reg == $past(an_stat.lp_np_able))
        else $error("partner next page ability wrong");
    a_np_able_set:
    assert property (an_stat.np_able |=> npc_reg)
        else $error("own next page bit not set");
    a_page_rx_set:
    assert property (lp_page_vld |=> prx_reg && lp_np_reg == $past(lp_page))
        else $error("page receipt not recorded");
    a_an_able_mirror:
    assert property (##1 lpan_reg == $past(an_stat.lp_an_able))
        else $error("partner auto-negotiation bit wrong");
    a_exp_reserved_zero:
    assert property (ta_load && cur_addr == ANG_OFS_EXPANSION
                     |=> sh_reg[15:5] == 11'h000)
        else $error("reserved expansion bits not zero");
    a_np_tx_write:
    assert property (s_np_write |=> np_tx_reg == ($past(wr_data)
                     & ANG_NP_TX_WMASK) ##1 np_tx_word[15] == np_tx_reg[15])
        else $error("next page write not taken");
    a_toggle_inverse:
    assert property (##2 np_tx_word[ANG_NP_TOGGLE]
                     == !$past(an_stat.tx_toggle, 2))
        else $error("toggle bit not inverted");
    a_test_mode_dec:
    assert property (gig_reg[15:13] == 3'h2
                     |=> gig_ctrl.test_mode == TM_MASTER_JIT)
        else $error("test mode decode wrong");
    a_ms_force_gate:
    assert property (!gig_reg[ANG_GC_MS_MANUAL] |=> !gig_ctrl.ms_force_master
                     && !gig_ctrl.ms_force_slave)
        else $error("master/slave forced without manual enable");
    a_read_clears:
    assert property (s_exp_read_quiet |=> !pdf_reg && !prx_reg && !npc_reg)
        else $error("held bits not cleared by read");

endmodule

// [verif/ang_regs_tb.sv]
// Self-checking bench for the management register block.
// Assumes the station model is the only master on the management link.
`timescale 1ns/10ps
module ang_regs_tb;
    import ang_pkg::*;
    localparam logic [4:0] PHY = 5'h05;
    logic          clk_sys = 1'b0;
    logic          rst = 1'b1;
    logic          mdc;
    logic          mdio_wire;
    logic          mdio_out;
    logic          mdio_oe;
    ang_an_stat_s  an_stat = 5'b00001;
    logic          lp_page_vld = 1'b0;
    logic [15:0]   lp_page = 16'h0000;
    logic [15:0]   np_tx_word;
    ang_gig_ctrl_s gig_ctrl;
    int            n_mismatch = 0;
    int            samples_checked = 0;

    always #10 clk_sys = ~clk_sys;

    ang_regs #(.PHY_ADDR(PHY), .PRE_LEN(16)) u_dut (
        .clk_sys(clk_sys), .rst(rst), .mdc(mdc), .mdio_in(mdio_wire),
        .mdio_out(mdio_out), .mdio_oe(mdio_oe), .an_stat(an_stat),
        .lp_page_vld(lp_page_vld), .lp_page(lp_page),
        .np_tx_word(np_tx_word), .gig_ctrl(gig_ctrl)
    );

    ang_sta_model #(.PRE(16)) u_sta (
        .mdc(mdc), .mdio_wire(mdio_wire),
        .dut_out(mdio_out), .dut_oe(mdio_oe)
    );

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic rd_chk(input logic [4:0] ra, input logic [15:0] exp);
        logic [15:0] d;
        u_sta.rd(PHY, ra, d);
        chk(d, exp);
    endtask

    // Order: pd_fault, lp_np_able, np_able, lp_an_able, tx_toggle
    task automatic set_st(input logic [4:0] s);
        @(posedge clk_sys);
        an_stat <= s;
    endtask

    task automatic t_reset();
        rd_chk(5'h06, 16'h0004);
        rd_chk(5'h06, 16'h0000);
        rd_chk(5'h07, 16'h23FF);
        chk(np_tx_word, 16'h23FF);
        rd_chk(5'h08, 16'h0000);
        rd_chk(5'h09, 16'h0000);
        chk({8'h00, gig_ctrl}, 16'h0000);
    endtask

    task automatic t_sticky();
        set_st(5'b01011);
        @(posedge clk_sys);
        an_stat.pd_fault <= 1'b1;
        lp_page_vld <= 1'b1;
        lp_page <= 16'hDABC;
        @(posedge clk_sys);
        an_stat.pd_fault <= 1'b0;
        lp_page_vld <= 1'b0;
        rd_chk(5'h06, 16'h001B);
        rd_chk(5'h06, 16'h0009);
        rd_chk(5'h08, 16'hDABC);
        u_sta.wr(PHY, 5'h06, 16'hFFFF);
        u_sta.wr(PHY, 5'h08, 16'h0000);
        rd_chk(5'h06, 16'h0009);
        rd_chk(5'h08, 16'hDABC);
        // Conditions held through the read keep their bits up
        set_st(5'b11111);
        rd_chk(5'h06, 16'h001D);
        rd_chk(5'h06, 16'h001D);
        set_st(5'b00001);
        rd_chk(5'h06, 16'h0014);
        rd_chk(5'h06, 16'h0000);
    endtask

    task automatic t_tx();
        // Slow station here to cover a long link period
        u_sta.half = 160;
        u_sta.wr(PHY, 5'h07, 16'hFFFF);
        rd_chk(5'h07, 16'hB7FF);
        chk(np_tx_word, 16'hB7FF);
        u_sta.half = 80;
        u_sta.wr(PHY, 5'h07, 16'h0000);
        set_st(5'b00000);
        rd_chk(5'h07, 16'h0800);
        u_sta.wr(PHY, 5'h07, 16'h5A5A);
        rd_chk(5'h07, 16'h1A5A);
        chk(np_tx_word, 16'h1A5A);
    endtask

    task automatic t_gig();
        logic [15:0] wv[5];
        logic [7:0]  gv[5];
        logic [2:0]  c;
        logic [7:0]  gx;
        wv = '{16'h1E00, 16'h1000, 16'h0800, 16'h0400, 16'h0200};
        gv = '{8'h1B, 8'h14, 8'h00, 8'h02, 8'h01};
        for (int i = 0; i < 8; i++) begin
            c = i[2:0];
            u_sta.wr(PHY, 5'h09, {c, 13'h0000});
            rd_chk(5'h09, {c, 13'h0000});
            gx = {(i < 5) ? c : 3'h0, 5'h00};
            chk({8'h00, gig_ctrl}, {8'h00, gx});
        end
        for (int i = 0; i < 5; i++) begin
            u_sta.wr(PHY, 5'h09, wv[i]);
            rd_chk(5'h09, wv[i]);
            chk({8'h00, gig_ctrl}, {8'h00, gv[i]});
        end
    endtask

    // Other address, unmapped place, pins not driven for a stranger
    task automatic t_refuse();
        logic [15:0] d;
        u_sta.wr(PHY ^ 5'h01, 5'h09, 16'hFFFF);
        rd_chk(5'h09, 16'h0200);
        u_sta.rd(PHY ^ 5'h01, 5'h09, d);
        chk(d, 16'hFFFF);
        u_sta.wr(PHY, 5'h1F, 16'hFFFF);
        rd_chk(5'h1F, 16'h0000);
        rd_chk(5'h07, 16'h1A5A);
    endtask

    task automatic print_verdict();
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        t_reset();
        t_sticky();
        t_tx();
        t_gig();
        t_refuse();
        print_verdict();
    end

    // A hang counts as a mismatch
    initial begin
        repeat (100000) @(posedge clk_sys);
        n_mismatch++;
        print_verdict();
    end
endmodule

// [verif/ang_sta_model.sv]
// Station manager model: drives mdc and mdio frames, samples read data.
// Assumes the block releases mdio when mdio_oe is low; line has a pull-up.
// Assumes a 20 ns system clock rising 10 ns past each 20 ns mark.
`timescale 1ns/10ps
module ang_sta_model #(
    parameter int PRE = 32
) (
    // Link pins
    output logic       mdc,
    output logic       mdio_wire,
    // Block side of the data pin
    input  wire logic  dut_out,
    input  wire logic  dut_oe
);
    logic sta_oe;
    logic sta_dat;
    int   half = 80;

    // Both driving is a collision, shown as unknown
    assign mdio_wire = dut_oe ? (sta_oe ? 1'bx : dut_out)
                              : (sta_oe ? sta_dat : 1'b1);

    // Clock stands low between frames
    initial begin
        mdc = 1'b0;
        sta_oe = 1'b0;
        sta_dat = 1'b1;
    end

    task automatic bit_cyc(input logic drv, input logic b, output logic s);
        sta_oe = drv;
        sta_dat = b;
        #(half);
        mdc = 1'b1;
        s = mdio_wire;
        #(half);
        mdc = 1'b0;
    endtask

    task automatic hdr(input logic [1:0] op, input logic [4:0] phy,
                       input logic [4:0] ra);
        logic [13:0] h;
        logic        s;
        h = {2'b01, op, phy, ra};
        // Start on a falling system edge, never on a sampling one
        #(20 - ($time % 20));
        for (int i = 0; i < PRE; i++) bit_cyc(1'b1, 1'b1, s);
        for (int i = 13; i >= 0; i--) bit_cyc(1'b1, h[i], s);
    endtask

    // Host decides bit 15 of the transmit page word
    task automatic wr(input logic [4:0] phy, input logic [4:0] ra,
                      input logic [15:0] d);
        logic [17:0] t;
        logic        s;
        t = {2'b10, d};
        hdr(2'b01, phy, ra);
        for (int i = 17; i >= 0; i--) bit_cyc(1'b1, t[i], s);
        sta_oe = 1'b0;
        #(2 * half);
    endtask

    task automatic rd(input logic [4:0] phy, input logic [4:0] ra,
                      output logic [15:0] d);
        logic s;
        hdr(2'b10, phy, ra);
        bit_cyc(1'b0, 1'b1, s);
        bit_cyc(1'b0, 1'b1, s);
        for (int i = 15; i >= 0; i--) bit_cyc(1'b0, 1'b1, d[i]);
        // Gap lets the block release before the next frame
        #(2 * half);
    endtask
endmodule
